/* rtl/lclt_pkg.sv */
// constants shared by the linear compare, latch and timer block
package lclt_pkg;
    // ************************************************
    // structure
    // ************************************************
    localparam int LCLT_SETS = 10;
    localparam int LCLT_CHANS = 4;
    localparam int LCLT_STEP_W = 14;
    localparam int LCLT_INTERVAL_W = 14;
    localparam int LCLT_EVENT_W = 18;

    // ************************************************
    // register byte offsets
    // ************************************************
    localparam logic [11:0] LIN_ENABLE_OFS = 12'h000;
    localparam logic [11:0] MANUAL_TRIG_OFS = 12'h004;
    localparam logic [11:0] DI_STATUS_OFS = 12'h008;
    localparam logic [11:0] LATCH_EVENT_OFS = 12'h00c;
    localparam logic [11:0] LATCH_CFG_OFS = 12'h010;
    localparam logic [11:0] EVENT_ENABLE_OFS = 12'h014;
    localparam logic [11:0] ROUTE_BASE = 12'h020;
    localparam logic [11:0] LATCH_VALUE_BASE = 12'h040;
    localparam logic [11:0] TIMER_CTRL_BASE = 12'h060;
    localparam logic [11:0] LIN_SET_BASE = 12'h200;
    localparam logic [3:0] LIN_FIRST_OFS = 4'h0;
    localparam logic [3:0] LIN_REPEAT_OFS = 4'h4;
    localparam logic [3:0] LIN_STEP_OFS = 4'h8;
    localparam logic [3:0] LIN_SELECT_OFS = 4'hc;

    // ************************************************
    // field positions
    // ************************************************
    localparam int LATCH_EDGE_LSB = 4;
    localparam int DI_LATCH_LSB = 4;
    localparam int DI_INDEX_LSB = 8;
    localparam int EVT_GENERAL_LSB = 4;
    localparam int EVT_LINEAR_LSB = 8;
    localparam int TMR_INPUT_EN_BIT = 14;
    localparam int TMR_EDGE_BIT = 15;
    localparam int TMR_RUN_BIT = 16;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [9:0] LIN_ENABLE_RST = 10'h000;
    localparam logic [7:0] LATCH_CFG_RST = 8'h00;
    localparam logic [17:0] EVENT_ENABLE_RST = 18'h00000;

    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int TIMER_BASE_NS = 25;
    localparam int TIMER_MULT = 16;
    localparam int TIMER_ADD = 4;
endpackage

/* rtl/lclt_top.sv */
// linear compare trigger sets, manual trigger, input status, latch and tick timers
`timescale 1ns/100ps
// Contract
// - ten independent compare sets, each may watch any position counter
// - each set holds first position, repeat count and signed step
// - nonzero repeat count gives repeat count plus one pulses, then stops
// - after N pulses the next target is first position plus N steps
// - step magnitude 1..8191 either sign; sign sets compare direction
// - repeat count zero keeps triggering until the set is reset
// - repeat count is a 32-bit value per set
// - each channel takes a mask of sets; several sets may share one
// - per-set enable bit; disabled sets never trigger
// - manual command gives one trigger pulse on the chosen channel
// - general, latch and index input levels read as three 4-bit maps
// - enabled latch captures its channel counter on the selected edge
// - edge select 0 captures falling edge, 1 captures rising edge
// - capture sets the event flag; reading the status clears it
// - latch event flags sit in bits 0 to 3, one per channel
// - last captured value per channel stays readable
// - timer starts by software or general input edge, stops by software
// - per-timer input start enable and falling/rising edge select
// - tick period is (interval times 16 plus 4) times 25 ns
// - timer control bit written 0 stops, written 1 starts
// - latch, general input and set events each enableable as sources
module lclt_top
    import lclt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [127:0] position_count,
    input wire logic [3:0] general_input,
    input wire logic [3:0] latch_input,
    input wire logic [3:0] encoder_index_input,
    output logic [3:0] trigger_output,
    output logic [3:0] timer_tick,
    output logic [17:0] event_source
);
    // ************************************************
    // helpers and state
    // ************************************************
    // picks one of the four 32-bit position counters
    function automatic logic [31:0] pick_count(input logic [127:0] all, input logic [1:0] sel);
        pick_count = all[sel*32 +: 32];
    endfunction

    logic bus_done;
    logic wr_done;
    logic [9:0] lin_enable;
    logic [7:0] latch_cfg;
    logic [17:0] event_enable;
    logic [9:0] set_route_mask [LCLT_CHANS];
    logic [31:0] first_trigger_position [LCLT_SETS];
    logic [31:0] repeat_count [LCLT_SETS];
    logic [LCLT_STEP_W-1:0] step [LCLT_SETS];
    logic [1:0] count_select [LCLT_SETS];
    logic [31:0] target [LCLT_SETS];
    logic [31:0] pulses_done [LCLT_SETS];
    logic [LCLT_SETS-1:0] set_active;
    logic [LCLT_SETS-1:0] set_fire;
    logic [11:0] sync_a;
    logic [11:0] sync_b;
    logic [11:0] sync_c;
    logic [3:0] capture_event_flags;
    logic [3:0] latch_hit;
    logic [3:0] general_hit;
    logic [31:0] latch_value [LCLT_CHANS];
    logic [LCLT_INTERVAL_W-1:0] timer_interval [LCLT_CHANS];
    logic [3:0] input_start_enable;
    logic [3:0] input_start_edge;
    logic [3:0] timer_running;
    logic [17:0] timer_count [LCLT_CHANS];
    logic [4:0] base_acc;
    logic base_tick;
    logic [5:0] base_sum;
    logic [31:0] next_prdata;
    logic next_slverr;

    // a transfer completes in its access phase once pready is seen high
    assign bus_done = psel & penable & pready;
    assign wr_done = bus_done & pwrite;

    // ************************************************
    // apb slave
    // ************************************************
    // read data is formed in the setup cycle so prdata leaves a flop
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        if (paddr[11:8] == LIN_SET_BASE[11:8]) begin
            if (paddr[7:4] < 4'(LCLT_SETS) && paddr[1:0] == 2'b00) begin
                unique case (paddr[3:0])
                    LIN_FIRST_OFS: next_prdata = first_trigger_position[paddr[7:4]];
                    LIN_REPEAT_OFS: next_prdata = repeat_count[paddr[7:4]];
                    LIN_STEP_OFS: next_prdata = {{18{step[paddr[7:4]][13]}}, step[paddr[7:4]]};
                    LIN_SELECT_OFS: next_prdata = {30'h0, count_select[paddr[7:4]]};
                    default: next_slverr = 1'b1;
                endcase
            end else begin
                next_slverr = 1'b1;
            end
        end else if (paddr[11:4] == ROUTE_BASE[11:4] && paddr[1:0] == 2'b00) begin
            next_prdata = {22'h0, set_route_mask[paddr[3:2]]};
        end else if (paddr[11:4] == LATCH_VALUE_BASE[11:4] && paddr[1:0] == 2'b00) begin
            next_prdata = latch_value[paddr[3:2]];
        end else if (paddr[11:4] == TIMER_CTRL_BASE[11:4] && paddr[1:0] == 2'b00) begin
            next_prdata = {15'h0, timer_running[paddr[3:2]], input_start_edge[paddr[3:2]],
                input_start_enable[paddr[3:2]], timer_interval[paddr[3:2]]};
        end else begin
            unique case (paddr)
                LIN_ENABLE_OFS: next_prdata = {22'h0, lin_enable};
                MANUAL_TRIG_OFS: next_prdata = 32'h0000_0000;
                DI_STATUS_OFS: next_prdata = {20'h0, sync_b[11:8], sync_b[7:4], sync_b[3:0]};
                LATCH_EVENT_OFS: next_prdata = {28'h0, capture_event_flags};
                LATCH_CFG_OFS: next_prdata = {24'h0, latch_cfg};
                EVENT_ENABLE_OFS: next_prdata = {14'h0, event_enable};
                default: next_slverr = 1'b1;
            endcase
        end
    end

    // one wait-free access phase: pready rises the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable & ~pready;
            if (psel & ~penable) begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= next_slverr;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // global control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lin_enable <= LIN_ENABLE_RST;
            latch_cfg <= LATCH_CFG_RST;
            event_enable <= EVENT_ENABLE_RST;
        end else if (wr_done) begin
            if (paddr == LIN_ENABLE_OFS)
                lin_enable <= pwdata[9:0];
            if (paddr == LATCH_CFG_OFS)
                latch_cfg <= pwdata[7:0];
            if (paddr == EVENT_ENABLE_OFS)
                event_enable <= pwdata[17:0];
        end
    end

    // ************************************************
    // linear compare sets
    // ************************************************
    for (genvar s = 0; s < LCLT_SETS; s++) begin : g_set
        logic set_wr;
        logic [31:0] diff;
        logic reached;
        assign set_wr = wr_done && paddr[11:8] == LIN_SET_BASE[11:8] && paddr[7:4] == 4'(s);
        assign diff = pick_count(position_count, count_select[s]) - target[s];
        // the sign of the step decides which side of the target counts as reached
        assign reached = step[s][LCLT_STEP_W-1] ? (diff[31] | (diff == 32'h0)) : ~diff[31];

        // parameters for this set
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                first_trigger_position[s] <= 32'h0000_0000;
                repeat_count[s] <= 32'h0000_0000;
                step[s] <= 14'h0001;
                count_select[s] <= 2'h0;
            end else if (set_wr) begin
                unique case (paddr[3:0])
                    LIN_FIRST_OFS: first_trigger_position[s] <= pwdata;
                    LIN_REPEAT_OFS: repeat_count[s] <= pwdata;
                    LIN_STEP_OFS: step[s] <= pwdata[LCLT_STEP_W-1:0];
                    LIN_SELECT_OFS: count_select[s] <= pwdata[1:0];
                    default: ;
                endcase
            end
        end

        // a disabled or reconfigured set rearms at its first position
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                target[s] <= 32'h0000_0000;
                pulses_done[s] <= 32'h0000_0000;
                set_active[s] <= 1'b0;
                set_fire[s] <= 1'b0;
            end else if (!lin_enable[s] || set_wr) begin
                target[s] <= first_trigger_position[s];
                pulses_done[s] <= 32'h0000_0000;
                set_active[s] <= 1'b1; // armed here, but fires only once enabled
                set_fire[s] <= 1'b0;
            end else if (set_active[s] && reached) begin
                set_fire[s] <= 1'b1;
                target[s] <= target[s] + {{18{step[s][LCLT_STEP_W-1]}}, step[s]};
                pulses_done[s] <= pulses_done[s] + 32'h1;
                // zero repeat count never stops; else stop after repeat plus one
                if (repeat_count[s] != 32'h0 && pulses_done[s] == repeat_count[s])
                    set_active[s] <= 1'b0;
            end else begin
                if (step[s] == 14'h0000 && lin_enable[s])
                    set_active[s] <= 1'b0; // zero step is illegal, the set idles
                set_fire[s] <= 1'b0;
            end
        end
    end

    // ************************************************
    // channel routing and manual trigger
    // ************************************************
    for (genvar c = 0; c < LCLT_CHANS; c++) begin : g_chan
        logic route_wr;
        assign route_wr = wr_done && paddr[11:4] == ROUTE_BASE[11:4] && paddr[3:2] == 2'(c);

        // route mask for this channel
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
                set_route_mask[c] <= 10'h000;
            else if (route_wr)
                set_route_mask[c] <= pwdata[9:0];
        end

        // any routed set or a manual command makes a one-cycle pulse
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
                trigger_output[c] <= 1'b0;
            else
                trigger_output[c] <= |(set_fire & set_route_mask[c])
                    | (wr_done && paddr == MANUAL_TRIG_OFS && pwdata[c]);
        end
    end

    // ************************************************
    // input synchronisers and edges
    // ************************************************
    // pins pass two flops; the third only delays for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 12'h000;
            sync_b <= 12'h000;
            sync_c <= 12'h000;
        end else begin
            sync_a <= {encoder_index_input, latch_input, general_input};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    for (genvar c = 0; c < LCLT_CHANS; c++) begin : g_edge
        // edge select 1 is rising, 0 is falling
        assign latch_hit[c] = latch_cfg[c] & (latch_cfg[LATCH_EDGE_LSB+c]
            ? (sync_b[DI_LATCH_LSB+c] & ~sync_c[DI_LATCH_LSB+c])
            : (~sync_b[DI_LATCH_LSB+c] & sync_c[DI_LATCH_LSB+c]));
        assign general_hit[c] = input_start_edge[c]
            ? (sync_b[c] & ~sync_c[c]) : (~sync_b[c] & sync_c[c]);
    end

    // ************************************************
    // position latch
    // ************************************************
    // only flags that went out on the bus are cleared, and a new capture wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            capture_event_flags <= 4'h0;
        else if (bus_done && !pwrite && paddr == LATCH_EVENT_OFS)
            capture_event_flags <= (capture_event_flags & ~prdata[3:0]) | latch_hit;
        else
            capture_event_flags <= capture_event_flags | latch_hit;
    end

    for (genvar c = 0; c < LCLT_CHANS; c++) begin : g_latch
        // captured counter value
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
                latch_value[c] <= 32'h0000_0000;
            else if (latch_hit[c])
                latch_value[c] <= pick_count(position_count, 2'(c));
        end
    end

    // ************************************************
    // tick timers
    // ************************************************
    // one spare bit keeps the sum from wrapping before it is compared
    assign base_sum = {1'b0, base_acc} + 6'(CLK_PERIOD_NS);

    // 25 ns base from an 8 ns clock by a fractional accumulator; jitter is one clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_acc <= 5'h00;
            base_tick <= 1'b0;
        end else if (base_sum >= 6'(TIMER_BASE_NS)) begin
            base_acc <= 5'(base_sum - 6'(TIMER_BASE_NS));
            base_tick <= 1'b1;
        end else begin
            base_acc <= base_sum[4:0];
            base_tick <= 1'b0;
        end
    end

    for (genvar c = 0; c < LCLT_CHANS; c++) begin : g_timer
        logic tmr_wr;
        logic [17:0] period;
        assign tmr_wr = wr_done && paddr[11:4] == TIMER_CTRL_BASE[11:4] && paddr[3:2] == 2'(c);
        assign period = 18'(timer_interval[c]) * 18'(TIMER_MULT) + 18'(TIMER_ADD);

        // configuration and run state
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                timer_interval[c] <= 14'h0000;
                input_start_enable[c] <= 1'b0;
                input_start_edge[c] <= 1'b0;
                timer_running[c] <= 1'b0;
            end else if (tmr_wr) begin
                timer_interval[c] <= pwdata[LCLT_INTERVAL_W-1:0];
                input_start_enable[c] <= pwdata[TMR_INPUT_EN_BIT];
                input_start_edge[c] <= pwdata[TMR_EDGE_BIT];
                timer_running[c] <= pwdata[TMR_RUN_BIT];
            end else if (input_start_enable[c] && general_hit[c]) begin
                timer_running[c] <= 1'b1;
            end
        end

        // counts base ticks while running, pulses at the end of each period
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                timer_count[c] <= 18'h00000;
                timer_tick[c] <= 1'b0;
            end else if (!timer_running[c]) begin
                timer_count[c] <= 18'h00000;
                timer_tick[c] <= 1'b0;
            end else if (base_tick && timer_count[c] >= period - 18'h1) begin
                timer_count[c] <= 18'h00000;
                timer_tick[c] <= 1'b1;
            end else begin
                timer_count[c] <= timer_count[c] + {17'h0, base_tick};
                timer_tick[c] <= 1'b0;
            end
        end
    end

    // ************************************************
    // event sources
    // ************************************************
    // gated one-cycle pulses for whatever interrupt logic sits outside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            event_source <= 18'h00000;
        else
            event_source <= event_enable & {set_fire, general_hit, latch_hit};
    end
endmodule

/* bench/lclt_properties.sv */
// port-level checks for the compare, latch and timer block
`timescale 1ns/100ps
module lclt_checker
    import lclt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [127:0] position_count,
    input wire logic [3:0] general_input,
    input wire logic [3:0] latch_input,
    input wire logic [3:0] encoder_index_input,
    input wire logic [3:0] trigger_output,
    input wire logic [3:0] timer_tick,
    input wire logic [17:0] event_source
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic man_wr;
    logic [3:0] man_mask;
    // manual command completes on this edge
    assign man_wr = psel && penable && pready && pwrite && paddr == MANUAL_TRIG_OFS;
    // keep the mask, since the master drops pwdata before the pulse shows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            man_mask <= 4'h0;
        end else if (man_wr) begin
            man_mask <= pwdata[3:0];
        end
    end
    // bus answers, refusals, pulses and reset quiet
    property p_answer; psel && !penable |=> pready; endproperty
    property p_single; pready |=> !pready; endproperty
    property p_err_ready; pslverr |-> pready; endproperty
    property p_misaligned; psel && !penable && paddr[1:0] != 2'b00 |=> pslverr; endproperty
    property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
    property p_manual;
        man_wr && pwdata[3:0] != 4'h0 |=> ##[0:1] ((trigger_output & man_mask) == man_mask);
    endproperty
    property p_tick_gap; timer_tick[0] |=> (!timer_tick[0]) [*8]; endproperty
    property p_quiet;
        $rose(presetn) |-> trigger_output == 4'h0 && timer_tick == 4'h0 && event_source == 18'h0;
    endproperty
    a_answer: assert property (p_answer) else $error("no ready after setup");
    a_single: assert property (p_single) else $error("ready longer than one cycle");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_misaligned: assert property (p_misaligned) else $error("misaligned not refused");
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    a_manual: assert property (p_manual) else $error("manual pulse missing");
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
    a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
    c_manual: cover property (man_wr);
    c_tick: cover property (timer_tick[0]);
    c_err: cover property (pslverr);
endmodule
bind lclt_top lclt_checker u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .position_count(position_count),
    .general_input(general_input), .latch_input(latch_input),
    .encoder_index_input(encoder_index_input), .trigger_output(trigger_output),
    .timer_tick(timer_tick), .event_source(event_source));

/* bench/lclt_field_model.sv */
// field side model: position counters and input pins
`timescale 1ns/100ps
module lclt_field_model
    import lclt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic count_en,
    input wire logic [11:0] pins,
    output logic [127:0] position_count,
    output logic [3:0] general_input,
    output logic [3:0] latch_input,
    output logic [3:0] encoder_index_input
);
    // counter 0 runs up, counter 1 down; idle counters return to base so runs repeat
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_count <= {32'h00000300, 32'h00000200, 32'h00001000, 32'h00000000};
        end else if (!count_en) begin
            position_count <= {32'h00000300, 32'h00000200, 32'h00001000, 32'h00000000};
        end else begin
            position_count[31:0] <= position_count[31:0] + 32'h1;
            position_count[63:32] <= position_count[63:32] - 32'h1;
        end
    end
    // pin levels as the bench sets them: index, latch, general
    assign {encoder_index_input, latch_input, general_input} = pins;
endmodule

/* bench/testbench.sv */
// self-checking bench: register traffic, trigger runs, latch and timer checks
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t got %h expected %h", $time, (g), (e)); end end
module testbench
    import lclt_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic count_en = 1'b0, err, pready, pslverr;
    logic [11:0] paddr = 12'h000, pins = 12'h010;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [127:0] position_count;
    logic [3:0] general_input, latch_input, encoder_index_input, trigger_output, timer_tick;
    logic [17:0] event_source;
    logic [5:0] mon;
    logic [31:0] pos_q[$];
    int failures = 0, num_checks = 0, csel = 0, c;
    lclt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .position_count(position_count), .general_input(general_input),
        .latch_input(latch_input), .encoder_index_input(encoder_index_input),
        .trigger_output(trigger_output), .timer_tick(timer_tick), .event_source(event_source));
    lclt_field_model field (.pclk(pclk), .presetn(presetn), .count_en(count_en), .pins(pins),
        .position_count(position_count), .general_input(general_input),
        .latch_input(latch_input), .encoder_index_input(encoder_index_input));
    // watched pulses: triggers, first timer tick, first latch event
    assign mon = {event_source[0], timer_tick[0], trigger_output};
    initial begin
        forever #4 pclk = ~pclk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one bus transfer; waiting one edge first keeps two requests from sharing a time step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            failures++;
            results();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // count pulses on one watched bit, noting the chosen counter at each
    task automatic count(input int cyc, input int b);
        c = 0;
        pos_q.delete();
        repeat (cyc) begin
            @(posedge pclk);
            if (mon[b] === 1'b1) begin
                c++;
                pos_q.push_back(position_count[32*csel +: 32]);
            end
        end
    endtask
    // one run of a compare set on channel 1; the counter only moves inside the run
    task automatic lin(input int s, input logic [31:0] first, rep, step, input int en, exp);
        logic [11:0] base;
        logic [31:0] sx;
        base = LIN_SET_BASE + 12'(s * 16);
        sx = {{18{step[13]}}, step[13:0]};
        csel = s;
        wr(base + 12'(LIN_FIRST_OFS), first);
        wr(base + 12'(LIN_REPEAT_OFS), rep);
        wr(base + 12'(LIN_STEP_OFS), step);
        rdchk(base + 12'(LIN_STEP_OFS), sx);
        wr(base + 12'(LIN_SELECT_OFS), 32'(s));
        wr(LIN_ENABLE_OFS, 32'(en << s));
        count_en <= 1'b1;
        count(150, 1);
        count_en <= 1'b0;
        wr(LIN_ENABLE_OFS, 32'h0);
        if (exp < 0) `CHK(c >= 30, 1'b1)
        else `CHK(c, exp)
        for (int i = 1; i < c; i++) `CHK(pos_q[i] - pos_q[i-1], sx)
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(LIN_ENABLE_OFS, 32'h0);
        rdchk(LATCH_CFG_OFS, 32'h0);
        rdchk(LIN_SET_BASE + 12'(LIN_STEP_OFS), 32'h1);
        apb(1'b0, 12'h018, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, 12'h002, 32'h1);
        `CHK(err, 1'b1)
        rdchk(LIN_ENABLE_OFS, 32'h0);
        $display("test registers done");
        for (int ch = 0; ch < 4; ch++) begin
            wr(MANUAL_TRIG_OFS, 32'(1 << ch));
            count(4, ch);
            `CHK(c, 1)
        end
        $display("test manual done");
        wr(ROUTE_BASE + 12'h004, 32'h3);
        wr(EVENT_ENABLE_OFS, 32'h3ff0f);
        lin(0, 32'd20, 32'd2, 32'd3, 1, 3);
        lin(1, 32'h00000fd0, 32'd1, 32'h3ffb, 1, 2);
        lin(0, 32'd10, 32'd0, 32'd4, 1, -1);
        lin(0, 32'd10, 32'd0, 32'd4, 0, 0);
        $display("test linear done");
        wr(LATCH_CFG_OFS, 32'h27);
        count_en <= 1'b1;
        pins <= 12'h064;
        count(10, 5);
        `CHK(c, 1)
        count_en <= 1'b0;
        rdchk(LATCH_EVENT_OFS, 32'h3);
        rdchk(LATCH_EVENT_OFS, 32'h0);
        rdchk(DI_STATUS_OFS, 32'h064);
        apb(1'b0, LATCH_VALUE_BASE, 32'h0);
        `CHK(rd > 32'h1 && rd < 32'h8, 1'b1)
        $display("test latch done");
        wr(TIMER_CTRL_BASE, 32'h10000);
        count(250, 4);
        `CHK(c >= 19 && c <= 21, 1'b1)
        wr(TIMER_CTRL_BASE, 32'h10001);
        count(250, 4);
        `CHK(c >= 3 && c <= 5, 1'b1)
        wr(TIMER_CTRL_BASE, 32'h0);
        count(100, 4);
        `CHK(c, 0)
        wr(TIMER_CTRL_BASE, 32'hc000);
        count(40, 4);
        `CHK(c, 0)
        pins <= 12'h065;
        count(250, 4);
        `CHK(c >= 18 && c <= 21, 1'b1)
        rdchk(TIMER_CTRL_BASE, 32'h1c000);
        wr(TIMER_CTRL_BASE, 32'h0);
        $display("test timer done");
        results();
    end
endmodule
